/* File: rtl/scm_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Tri-state data in read, open-collector in programming
// - Serial clock edge advances address/bit counter
// - Reset/enable pin: low resets, high enables
// - Reset level clears address and bit counters in read mode
// - Enable level and chip enable drive data
// - Reset pin polarity is a stored setting
// - Enabled chip lets clock advance address
// - Chip enable high halts counters in read mode, standby
// - Chip enable ignored for enabling in programming
// - Cascade output low on the edge after the bit at maximum address
// - Cascade stays low while chip enabled
// - Then cascade follows chip enable
// - After disable, cascade high until reread
// - Write protect guards lowest block while chip enable low
// - Region guards act only while programming
// - Device select matters only in programming
// - Ready pulled low during power-up reset
// - Power-up resets the address counter
// - After last bit, data pin released
// - Standby keeps data pin high-impedance
module scm_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic master_serial_clock,
	input wire logic chip_enable_n,
	input wire logic reset_oe_pin,
	input wire logic program_mode_select_n,
	input wire logic write_protect,
	input wire logic region_guard_one,
	input wire logic region_guard_two,
	input wire logic device_select_bit,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe_n,
	output logic cascade_out_n,
	input wire logic ready_in,
	output logic ready_out,
	output logic ready_oe_n,
	output logic standby
);
	typedef struct packed {
		logic [scm_pkg::SYNC_W-1:0] s1;
		logic [scm_pkg::SYNC_W-1:0] s2;
		logic [scm_pkg::SYNC_W-1:0] s3;
		logic [scm_pkg::SYNC_W-1:0] filt;
		logic prog_prev;
		logic reset_active_high;
		logic [scm_pkg::ADDR_W-1:0] fetch_addr;
		logic fetch_done;
		logic rd_ok;
		logic [scm_pkg::ADDR_W-1:0] addr;
		logic last_shown;
		logic done;
		logic pin_bit;
		logic drive_n;
		logic refuse_low;
		scm_pkg::scm_cas_e cas;
		logic cas_out_n;
		logic [scm_pkg::PU_W-1:0] pu_cnt;
		logic ready_rel;
		logic standby;
	} scm_top_s;

	scm_top_s st;
	scm_top_s next_st;

	// Raw pin levels gathered into one vector for the synchroniser
	logic [scm_pkg::SYNC_W-1:0] pins;
	logic [scm_pkg::SYNC_W-1:0] f;
	// Mode and edge decodes, all from filtered levels
	logic prog;
	// One cycle per filtered serial clock rising edge
	logic rise;
	logic rst_lvl;
	logic read_act;
	logic selected;
	logic clear;

	// Array port, fetch stream into the buffer and the stream out to the pin
	scm_mem_if mif();
	scm_stream_if fetch_s();
	scm_stream_if out_s();

	scm_mem u_mem (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mif(mif.store)
	);

	// Two entries keep a prefetched bit ready while the next read is in flight
	scm_buf u_buf (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.flush(clear),
		.up(fetch_s.snk),
		.dn(out_s.src)
	);

	always_comb
	begin
		pins = '0;
		pins[scm_pkg::IN_CLK] = master_serial_clock;
		pins[scm_pkg::IN_CE_N] = chip_enable_n;
		pins[scm_pkg::IN_RSTOE] = reset_oe_pin;
		pins[scm_pkg::IN_PROG_N] = program_mode_select_n;
		pins[scm_pkg::IN_WP] = write_protect;
		pins[scm_pkg::IN_G1] = region_guard_one;
		pins[scm_pkg::IN_G2] = region_guard_two;
		pins[scm_pkg::IN_DSEL] = device_select_bit;
		pins[scm_pkg::IN_DATA] = data_in;
	end

	always_comb
	begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// A level counts once the second and third stages agree
		next_st.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);
		f = next_st.filt;

		prog = ~f[scm_pkg::IN_PROG_N];
		rise = f[scm_pkg::IN_CLK] & ~st.filt[scm_pkg::IN_CLK];
		rst_lvl = (f[scm_pkg::IN_RSTOE] == st.reset_active_high);
		read_act = ~prog & ~f[scm_pkg::IN_CE_N] & ~rst_lvl;
		selected = prog & (f[scm_pkg::IN_DSEL] == scm_pkg::DEV_SELECT_MATCH);
		// A mode change restarts the counters so both modes start at address zero
		clear = (~prog & rst_lvl) | (prog != st.prog_prev);
		next_st.prog_prev = prog;

		mif.rd_addr = st.fetch_addr;
		mif.wr_en = 1'b0;
		mif.wr_addr = st.addr;
		mif.wr_data = f[scm_pkg::IN_DATA];

		fetch_s.valid = st.rd_ok & ~st.fetch_done & ~prog;
		fetch_s.data = mif.rd_data;
		out_s.ready = rise & read_act & ~st.done & ~st.last_shown;

		// Prefetch: read data are good one cycle after the address settles
		next_st.rd_ok = 1'b1;
		if (fetch_s.valid & fetch_s.ready)
		begin
			next_st.rd_ok = 1'b0;
			if (st.fetch_addr == scm_pkg::ADDR_MAX)
				next_st.fetch_done = 1'b1;
			else
				next_st.fetch_addr = st.fetch_addr + scm_pkg::ADDR_ONE;
		end

		// Read: one bit per rising edge; an empty buffer means the clock outran the fetch
		if (out_s.ready & out_s.valid)
		begin
			next_st.pin_bit = out_s.data;
			if (st.addr == scm_pkg::ADDR_MAX)
				next_st.last_shown = 1'b1;
			else
				next_st.addr = st.addr + scm_pkg::ADDR_ONE;
		end
		else if (rise & read_act & st.last_shown & ~st.done)
			next_st.done = 1'b1;

		// Programming: each selected edge writes the pin level, unless the block is guarded, and advances the counter; past the last address it stores the reset polarity
		if (rise & selected)
		begin
			next_st.refuse_low = 1'b0;
			if (st.done)
				next_st.reset_active_high = f[scm_pkg::IN_DATA];
			else
			begin
				if (scm_pkg::scm_guarded(st.addr, f[scm_pkg::IN_CE_N], f[scm_pkg::IN_WP],
					f[scm_pkg::IN_G1], f[scm_pkg::IN_G2]))
					next_st.refuse_low = 1'b1;
				else
					mif.wr_en = 1'b1;
				if (st.addr == scm_pkg::ADDR_MAX)
					next_st.done = 1'b1;
				else
					next_st.addr = st.addr + scm_pkg::ADDR_ONE;
			end
		end
		// Open-collector style: only a low is ever driven in programming
		if (prog)
			next_st.pin_bit = 1'b0;

		// Clear comes last so it wins over any advance in the same cycle
		// Buffer is flushed too, so no stale prefetched bit survives a restart
		if (clear)
		begin
			next_st.fetch_addr = scm_pkg::ADDR_ZERO;
			next_st.fetch_done = 1'b0;
			next_st.rd_ok = 1'b0;
			next_st.addr = scm_pkg::ADDR_ZERO;
			next_st.last_shown = 1'b0;
			next_st.done = 1'b0;
			next_st.refuse_low = 1'b0;
		end

		// Cascade state looks at next done so it drops in the cycle the pin floats
		case (st.cas)
			scm_pkg::CAS_IDLE:
			begin
				if (read_act & next_st.done)
					next_st.cas = scm_pkg::CAS_LOW;
			end
			scm_pkg::CAS_LOW:
			begin
				if (prog | rst_lvl)
					next_st.cas = scm_pkg::CAS_IDLE;
				else if (f[scm_pkg::IN_CE_N])
					next_st.cas = scm_pkg::CAS_FOLLOW;
			end
			scm_pkg::CAS_FOLLOW:
			begin
				if (prog | rst_lvl)
					next_st.cas = scm_pkg::CAS_IDLE;
			end
			default:
			begin
				next_st.cas = scm_pkg::CAS_IDLE;
			end
		endcase
		if (next_st.cas == scm_pkg::CAS_LOW)
			next_st.cas_out_n = 1'b0;
		else if (next_st.cas == scm_pkg::CAS_FOLLOW)
			next_st.cas_out_n = f[scm_pkg::IN_CE_N];
		else
			next_st.cas_out_n = 1'b1;

		// Chip enable high leaves read_act low, so the pin floats in standby
		next_st.drive_n = ~((read_act & ~next_st.done) | (prog & next_st.refuse_low));
		next_st.standby = ~prog & f[scm_pkg::IN_CE_N];

		// Ready is held low until the pin synchronisers have settled
		if (st.pu_cnt != scm_pkg::PU_CYCLES)
			next_st.pu_cnt = st.pu_cnt + scm_pkg::PU_ONE;
		else
			next_st.ready_rel = 1'b1;
	end

	// Reset leaves the data and cascade pins released, the ready pin pulled low and the chip seen as deselected
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.s1 <= scm_pkg::SYNC_RESET;
			st.s2 <= scm_pkg::SYNC_RESET;
			st.s3 <= scm_pkg::SYNC_RESET;
			st.filt <= scm_pkg::SYNC_RESET;
			st.reset_active_high <= scm_pkg::POLARITY_RESET;
			st.drive_n <= 1'b1;
			st.cas <= scm_pkg::CAS_IDLE;
			st.cas_out_n <= 1'b1;
			st.standby <= 1'b1;
		end
		else
			st <= next_st;
	end

	// Pin outputs straight from registers, ready_out tied low; the pad pairs level and enable
	assign data_out = st.pin_bit;
	assign data_oe_n = st.drive_n;
	assign cascade_out_n = st.cas_out_n;
	assign ready_out = 1'b0;
	assign ready_oe_n = st.ready_rel;
	assign standby = st.standby;
endmodule : scm_top
`default_nettype wire

/* File: rtl/scm_pkg.sv */
package scm_pkg;
	localparam int ADDR_W = 16;
	localparam int DEPTH = 65536;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_MAX = 16'hffff;
	localparam int BUF_W = 1;

	// Write-protect regions are quarters, chosen by the top address bits
	localparam int BLOCK_W = 2;
	localparam logic [BLOCK_W-1:0] BLK_LOWEST = 2'h0;
	localparam logic [BLOCK_W-1:0] BLK_GUARD_ONE = 2'h1;
	localparam logic [BLOCK_W-1:0] BLK_GUARD_TWO = 2'h2;

	// Positions of the pins in the synchroniser vector
	localparam int SYNC_W = 9;
	localparam int IN_CLK = 0;
	localparam int IN_CE_N = 1;
	localparam int IN_RSTOE = 2;
	localparam int IN_PROG_N = 3;
	localparam int IN_WP = 4;
	localparam int IN_G1 = 5;
	localparam int IN_G2 = 6;
	localparam int IN_DSEL = 7;
	localparam int IN_DATA = 8;
	// Chip disabled and programming mode off until the pins are seen
	localparam logic [SYNC_W-1:0] SYNC_RESET = 9'h00a;

	localparam logic DEV_SELECT_MATCH = 1'b0;
	localparam logic POLARITY_RESET = 1'b0;
	localparam logic ERASED_BIT = 1'b1;

	localparam int PU_W = 3;
	localparam logic [PU_W-1:0] PU_ZERO = 3'h0;
	localparam logic [PU_W-1:0] PU_ONE = 3'h1;
	localparam logic [PU_W-1:0] PU_CYCLES = 3'h7;

	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_ONE = 2'h1;
	localparam logic [1:0] BUF_FULL = 2'h2;

	typedef enum {CAS_IDLE, CAS_LOW, CAS_FOLLOW} scm_cas_e;

	function automatic logic scm_guarded(input logic [ADDR_W-1:0] addr, input logic ce_n,
		input logic wp, input logic g1, input logic g2);
		logic [BLOCK_W-1:0] blk;
		blk = addr[ADDR_W-1 -: BLOCK_W];
		return (wp & ~ce_n & (blk == BLK_LOWEST)) | (g1 & (blk == BLK_GUARD_ONE))
			| (g2 & (blk == BLK_GUARD_TWO));
	endfunction : scm_guarded
endpackage : scm_pkg

/* File: rtl/scm_ifs.sv */
`timescale 1ns/1ns
`default_nettype none
interface scm_mem_if;
	logic [scm_pkg::ADDR_W-1:0] rd_addr;
	logic rd_data;
	logic wr_en;
	logic [scm_pkg::ADDR_W-1:0] wr_addr;
	logic wr_data;
	modport ctrl(output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport store(input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : scm_mem_if

interface scm_stream_if;
	logic valid;
	logic ready;
	logic [scm_pkg::BUF_W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : scm_stream_if
`default_nettype wire

/* File: rtl/scm_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module scm_mem (
	input wire logic ref_clk,
	input wire logic rst_n,
	scm_mem_if.store mif
);
	typedef struct packed {
		logic [scm_pkg::DEPTH-1:0] bits;
		logic rd_data;
	} scm_mem_s;

	scm_mem_s st;
	scm_mem_s next_st;

	always_comb
	begin
		next_st = st;
		if (mif.wr_en)
		begin
			next_st.bits[mif.wr_addr] = mif.wr_data;
		end
		next_st.rd_data = st.bits[mif.rd_addr];
	end

	// Reset stands in for an erased array; contents are not kept over power loss
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '{bits: {scm_pkg::DEPTH{scm_pkg::ERASED_BIT}}, rd_data: scm_pkg::ERASED_BIT};
		else
			st <= next_st;
	end

	assign mif.rd_data = st.rd_data;
endmodule : scm_mem
`default_nettype wire

/* File: rtl/scm_buf.sv */
`timescale 1ns/1ns
`default_nettype none
module scm_buf (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic flush,
	scm_stream_if.snk up,
	scm_stream_if.src dn
);
	typedef struct packed {
		logic [scm_pkg::BUF_W-1:0] head;
		logic [scm_pkg::BUF_W-1:0] tail;
		logic [1:0] count;
	} scm_buf_s;

	scm_buf_s st;
	scm_buf_s next_st;
	logic push;
	logic pop;

	always_comb
	begin
		up.ready = (st.count != scm_pkg::BUF_FULL);
		dn.valid = (st.count != scm_pkg::BUF_EMPTY);
		dn.data = st.head;
		push = up.valid & up.ready;
		pop = dn.valid & dn.ready;
		next_st = st;
		if (flush)
			next_st.count = scm_pkg::BUF_EMPTY;
		else if (push & pop)
		begin
			if (st.count == scm_pkg::BUF_ONE)
				next_st.head = up.data;
			else
			begin
				next_st.head = st.tail;
				next_st.tail = up.data;
			end
		end
		else if (pop)
		begin
			next_st.head = st.tail;
			next_st.count = st.count - scm_pkg::BUF_ONE;
		end
		else if (push)
		begin
			if (st.count == scm_pkg::BUF_EMPTY)
				next_st.head = up.data;
			else
				next_st.tail = up.data;
			next_st.count = st.count + scm_pkg::BUF_ONE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			st <= '{head: '0, tail: '0, count: scm_pkg::BUF_EMPTY};
		else
			st <= next_st;
	end
endmodule : scm_buf
`default_nettype wire

/* File: tb/scm_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module scm_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic master_serial_clock,
	input wire logic chip_enable_n,
	input wire logic reset_oe_pin,
	input wire logic program_mode_select_n,
	input wire logic data_out,
	input wire logic data_oe_n,
	input wire logic cascade_out_n,
	input wire logic ready_out,
	input wire logic ready_oe_n,
	input wire logic standby
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	wire logic rd_on = program_mode_select_n & reset_oe_pin;

	chk_reset_clears: assert property ((!reset_oe_pin && program_mode_select_n) [*6] |-> data_oe_n && cascade_out_n)
		else $error("counter reset left outputs active");
	chk_standby_hiz: assert property ((chip_enable_n && program_mode_select_n) [*6] |-> standby && data_oe_n)
		else $error("standby not entered or pin driven");
	chk_enable_drv: assert property ((rd_on && !chip_enable_n) [*6] |-> !data_oe_n || !cascade_out_n)
		else $error("enabled device not driving data");
	chk_drive_cause: assert property ($fell(data_oe_n) && $past(program_mode_select_n, 6) |-> rd_on && !chip_enable_n)
		else $error("data driver on without enable");
	chk_cascade_off: assert property (!cascade_out_n && program_mode_select_n |-> data_oe_n)
		else $error("data driven after last bit");
	chk_prog_oc: assert property (!program_mode_select_n [*6] |-> !data_out && !standby)
		else $error("programming mode pin or standby wrong");
	chk_ready_hold: assert property (!$fell(ready_oe_n) && !ready_out)
		else $error("ready pin pulled low after power-up");
	// Filter plus register puts the change three to four cycles after the pin
	chk_data_edge: assert property ($changed(data_out) && rd_on && $past(rd_on, 8) |-> $past(master_serial_clock, 3))
		else $error("data changed without serial rising edge");

	cov_drive: cover property ($fell(data_oe_n));
	cov_standby: cover property ($rose(standby));
	cov_prog: cover property (!program_mode_select_n && !data_oe_n);
endmodule : scm_chk

bind scm_top scm_chk u_scm_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.master_serial_clock(master_serial_clock),
	.chip_enable_n(chip_enable_n),
	.reset_oe_pin(reset_oe_pin),
	.program_mode_select_n(program_mode_select_n),
	.data_out(data_out),
	.data_oe_n(data_oe_n),
	.cascade_out_n(cascade_out_n),
	.ready_out(ready_out),
	.ready_oe_n(ready_oe_n),
	.standby(standby)
);
`default_nettype wire

/* File: tb/scm_host.sv */
`timescale 1ns/1ns
`default_nettype none
module scm_host (
	input wire logic ref_clk,
	input wire logic data_out,
	output logic sck,
	output logic ce_n,
	output logic roe,
	output logic prog_n,
	output logic drv
);
	initial
	begin
		sck = 1'b0;
		ce_n = 1'b1;
		roe = 1'b1;
		prog_n = 1'b1;
		drv = 1'b1;
	end
	// Waits past the pin filter so levels are seen on return
	task lvl(input logic c, input logic o, input logic p);
		@(posedge ref_clk);
		#1;
		ce_n = c;
		roe = o;
		prog_n = p;
		repeat (8) @(posedge ref_clk);
	endtask : lvl
	// Six-cycle phases stay clear of the two-cycle filter limit
	task tick(input logic d, output logic q);
		@(posedge ref_clk);
		#1;
		sck = 1'b1;
		drv = d;
		repeat (6) @(posedge ref_clk);
		#1;
		sck = 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		q = data_out;
		drv = 1'b1;
	endtask : tick
endmodule : scm_host
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic g1 = 1'b0;
	logic g2 = 1'b0;
	logic dsel = 1'b0;
	logic sck, ce_n, roe, prog_n, drv, dout, doe_n, cas_n, rdy, rdy_oe_n, stby, q;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	bit mem[64];

	always #20 ref_clk = ~ref_clk;

	scm_host u_scm_host (.ref_clk(ref_clk), .data_out(dout), .sck(sck), .ce_n(ce_n), .roe(roe),
		.prog_n(prog_n), .drv(drv));

	// Pull-up on the data pin; either side may pull it low
	scm_top u_scm_top (.ref_clk(ref_clk), .rst_n(rst_n), .master_serial_clock(sck),
		.chip_enable_n(ce_n), .reset_oe_pin(roe), .program_mode_select_n(prog_n),
		.write_protect(wp), .region_guard_one(g1), .region_guard_two(g2),
		.device_select_bit(dsel), .data_in(drv & (doe_n | dout)), .data_out(dout),
		.data_oe_n(doe_n), .cascade_out_n(cas_n), .ready_in(rdy_oe_n | rdy),
		.ready_out(rdy), .ready_oe_n(rdy_oe_n), .standby(stby));

	task test_done;
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task chk(input logic seen, input logic exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			test_done();
		end
	end

	// Reads from address zero with a standby pause halfway
	task rd(input int n);
		@(posedge ref_clk);
		#1;
		g1 = 1'($urandom);
		g2 = 1'($urandom);
		u_scm_host.lvl(1'b1, 1'b0, 1'b1);
		chk(doe_n, 1'b1);
		chk(cas_n, 1'b1);
		u_scm_host.lvl(1'b0, 1'b1, 1'b1);
		chk(doe_n, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			if (i == n / 2)
			begin
				u_scm_host.lvl(1'b1, 1'b1, 1'b1);
				chk(stby, 1'b1);
				chk(doe_n, 1'b1);
				u_scm_host.tick(1'b1, q);
				chk(q, mem[i - 1]);
				u_scm_host.lvl(1'b0, 1'b1, 1'b1);
			end
			u_scm_host.tick(1'b1, q);
			chk(q, mem[i]);
		end
	endtask : rd

	// Guard only bites with chip enable low
	task prog(input int n, input logic sel, input logic w, input logic c);
		logic d;
		@(posedge ref_clk);
		#1;
		dsel = sel;
		wp = w;
		u_scm_host.lvl(c, 1'b1, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			d = 1'($urandom);
			u_scm_host.tick(d, q);
			if (!sel && !(w && !c))
				mem[i] = d;
			if (!sel)
				chk(doe_n, !(w && !c));
			else
				chk(doe_n, 1'b1);
		end
		u_scm_host.lvl(c, 1'b1, 1'b1);
	endtask : prog

	initial
	begin
		foreach (mem[i])
			mem[i] = 1'b1;
		void'($urandom(52));
		repeat (16) @(posedge ref_clk);
		chk(rdy_oe_n, 1'b0);
		chk(stby, 1'b1);
		#1;
		rst_n = 1'b1;
		repeat (9) @(posedge ref_clk);
		#1;
		chk(rdy_oe_n, 1'b1);
		rd(8);
		prog(16, 1'b0, 1'b0, 1'($urandom));
		rd(16);
		prog(8, 1'b1, 1'b0, 1'b0);
		rd(16);
		prog(8, 1'b0, 1'b1, 1'b0);
		rd(16);
		test_done();
	end
endmodule : testbench
`default_nettype wire
